// *** design/ldst_exec.sv ***
// Executor of the load, store, transfer and exchange instruction group.
`timescale 1ns/100ps
module ldst_exec
  import ldst_pkg::*;
(
  // Clock and reset.
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  // Instruction hand-over from the fetch path.
  input  wire logic                      start,
  input  wire logic [7:0]                opcode,
  input  wire logic [7:0]                operand1,
  input  wire logic [7:0]                operand2,
  input  wire logic                      page_sel,
  // Execution status.
  output logic                           busy,
  output logic                           done,
  output logic                           illegal,
  output logic [1:0]                     byte_count,
  // Data memory.
  output logic [ldst_pkg::ADDR_W-1:0]    mem_addr,
  output logic                           mem_rd,
  output logic                           mem_wr,
  output logic [ldst_pkg::DATA_W-1:0]    mem_wdata,
  input  wire logic [ldst_pkg::DATA_W-1:0] mem_rdata,
  // Register file and flags.
  output logic [7:0]                     acc,
  output logic [7:0]                     idx_x,
  output logic [7:0]                     idx_y,
  output logic [7:0]                     stack_ptr,
  output logic                           flag_n,
  output logic                           flag_z
);

  ldst_entry_t           dec;
  ldst_entry_t           ent;
  ldst_state_t           state;
  ldst_state_t           next_state;
  logic [2:0]            cnt;
  logic [7:0]            op1;
  logic [7:0]            op2;
  logic                  page;
  logic [7:0]            ptr_lo;
  logic [7:0]            data_reg;
  logic [7:0]            gpr      [4];
  logic [7:0]            next_gpr [4];
  logic [ADDR_W-1:0]     next_addr;
  logic                  next_rd;
  logic                  next_wr;
  logic [7:0]            res;
  logic                  put_dst;
  logic                  put_src;

  ldst_decode u_dec
  (
    .opcode (opcode),
    .entry  (dec)
  );

  // Decode of the latched entry.
  wire logic       active    = (state != S_IDLE);
  wire logic       finish    = active && (cnt == ent.ncyc - CNT_FIRST);
  wire logic       take      = (state == S_IDLE) && start;
  wire logic       bad_op    = take && !dec.legal;
  wire logic       is_imm    = (ent.mode == M_IMM);
  wire logic       is_ptr    = (ent.mode == M_IDXIND) || (ent.mode == M_INDIDX);
  wire logic       is_swapm  = (ent.kind == K_SWAPM);
  wire logic       needs_rd  = ((ent.kind == K_LOAD) && !is_imm) || is_swapm;
  wire logic       needs_wr  = (ent.kind == K_STORE) || (ent.kind == K_STIMM);
  wire logic [7:0] src_val   = gpr[ent.src];
  wire logic [7:0] dst_val   = gpr[ent.dst];
  wire logic [7:0] dp_x      = op1 + idx_x;
  wire logic [7:0] dp_y      = op1 + idx_y;
  wire logic [7:0] page_hi   = {PAGE_PAD, page};

  // Data taken from memory is used the cycle it arrives, or from the holding copy.
  wire logic [7:0] load_val  = (state == S_RD) ? mem_rdata : data_reg;

  // Direct-page forms wrap inside the page; absolute forms carry into the high byte.
  wire logic [ADDR_W-1:0] abs_addr  = {op2, op1};
  wire logic [ADDR_W-1:0] absy_addr = abs_addr + {8'h00, idx_y};
  wire logic [ADDR_W-1:0] direct_addr =
    (ent.mode == M_DP)   ? {page_hi, op1}   :
    (ent.mode == M_DPX)  ? {page_hi, dp_x}  :
    (ent.mode == M_DPY)  ? {page_hi, dp_y}  :
    (ent.mode == M_ABS)  ? abs_addr         :
    (ent.mode == M_ABSY) ? absy_addr        :
                           {page_hi, idx_x};

  // Pointer low byte sits in the direct page; the high byte follows with wrap.
  wire logic [ADDR_W-1:0] ptr_first =
    (ent.mode == M_IDXIND) ? {page_hi, dp_x} : {page_hi, op1};
  wire logic [ADDR_W-1:0] ptr_next  = {mem_addr[15:8], mem_addr[7:0] + BYTE_ONE};
  wire logic [ADDR_W-1:0] ptr_eff   =
    {mem_rdata, ptr_lo} + ((ent.mode == M_INDIDX) ? {8'h00, idx_y} : 16'h0000);

  // Byte written: immediate, accumulator for a swap, else the source register.
  wire logic [7:0] wr_val =
    (ent.kind == K_STIMM) ? op2 :
    is_swapm              ? acc :
                            src_val;

  // Sequencer and memory requests.
  always_comb
  begin
    next_state = state;
    next_addr  = mem_addr;
    next_rd    = 1'h0;
    next_wr    = 1'h0;
    case (state)
      S_IDLE:
      begin
        if (take && dec.legal)
        begin
          next_state = S_ADDR;
        end
      end
      S_ADDR:
      begin
        if (is_ptr)
        begin
          next_addr  = ptr_first;
          next_rd    = 1'h1;
          next_state = S_PLO;
        end
        else if (needs_rd)
        begin
          next_addr  = direct_addr;
          next_rd    = 1'h1;
          next_state = S_RD;
        end
        else if (needs_wr)
        begin
          next_addr  = direct_addr;
          next_wr    = 1'h1;
          next_state = S_WAIT;
        end
        else
        begin
          next_state = S_WAIT;
        end
      end
      S_PLO:
      begin
        next_addr  = ptr_next;
        next_rd    = 1'h1;
        next_state = S_PHI;
      end
      S_PHI:
      begin
        next_addr  = ptr_eff;
        next_rd    = needs_rd;
        next_wr    = needs_wr;
        next_state = needs_rd ? S_RD : S_WAIT;
      end
      S_RD:
      begin
        // A swap writes the old accumulator back to the byte just read.
        next_wr    = is_swapm;
        next_state = S_WAIT;
      end
      S_WAIT:
      begin
        next_state = S_WAIT;
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
    // The cycle count from the table, not the access pattern, ends every instruction.
    if (finish)
    begin
      next_state = S_IDLE;
    end
  end

  // Result of the instruction, applied only in its last cycle.
  always_comb
  begin
    res     = src_val;
    put_dst = 1'h0;
    put_src = 1'h0;
    case (ent.kind)
      K_LOAD:
      begin
        res     = is_imm ? op1 : load_val;
        put_dst = finish;
      end
      K_COPY:
      begin
        res     = src_val;
        put_dst = finish;
      end
      K_SWAPR:
      begin
        res     = src_val;
        put_dst = finish;
        put_src = finish;
      end
      K_SWAPM:
      begin
        res     = load_val;
        put_dst = finish;
      end
      default:
      begin
        res     = src_val;
        put_dst = 1'h0;
        put_src = 1'h0;
      end
    endcase
  end

  // Flags change only where the entry marks them; all else holds.
  wire logic upd_nz = finish && ent.nz;
  wire logic next_n = upd_nz ? res[7] : flag_n;
  wire logic next_z = upd_nz ? (res == 8'h00) : flag_z;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_reg
      wire logic hit_dst = put_dst && (ent.dst == ldst_reg_t'(gi));
      wire logic hit_src = put_src && (ent.src == ldst_reg_t'(gi));
      wire logic hit_inc = finish && ent.incx && (gi == int'(R_X));
      assign next_gpr[gi] = hit_dst ? res :
                            hit_src ? dst_val :
                            hit_inc ? gpr[gi] + BYTE_ONE :
                                      gpr[gi];
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          gpr[gi] <= RST_GPR[gi];
        else
          gpr[gi] <= next_gpr[gi];
      end
    end
  endgenerate

  // Latch the instruction when it is taken.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ent  <= '{K_NONE, M_NONE, R_A, R_A, 2'h0, 3'h2, 1'h0, 1'h0, 1'h0};
      op1  <= 8'h00;
      op2  <= 8'h00;
      page <= 1'h0;
    end
    else if (take)
    begin
      ent  <= dec;
      op1  <= operand1;
      op2  <= operand2;
      page <= page_sel;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= S_IDLE;
      cnt   <= CNT_RST;
    end
    else
    begin
      state <= next_state;
      cnt   <= take ? CNT_FIRST : (active ? cnt + CNT_FIRST : CNT_RST);
    end
  end

  // Pointer low byte and read data are held for the later cycles.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ptr_lo   <= 8'h00;
      data_reg <= 8'h00;
    end
    else
    begin
      ptr_lo   <= (state == S_PLO) ? mem_rdata : ptr_lo;
      data_reg <= (state == S_RD) ? mem_rdata : data_reg;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_addr  <= {ADDR_W{1'b0}};
      mem_rd    <= 1'h0;
      mem_wr    <= 1'h0;
      mem_wdata <= 8'h00;
    end
    else
    begin
      mem_addr  <= next_addr;
      mem_rd    <= next_rd;
      mem_wr    <= next_wr;
      mem_wdata <= next_wr ? wr_val : mem_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      flag_n     <= RST_FLAG;
      flag_z     <= RST_FLAG;
      busy       <= 1'h0;
      done       <= 1'h0;
      illegal    <= 1'h0;
      byte_count <= BYTES_RST;
    end
    else
    begin
      flag_n     <= next_n;
      flag_z     <= next_z;
      busy       <= (next_state != S_IDLE);
      done       <= finish || bad_op;
      illegal    <= bad_op;
      byte_count <= take ? dec.nbytes : byte_count;
    end
  end

  assign acc       = gpr[R_A];
  assign idx_x     = gpr[R_X];
  assign idx_y     = gpr[R_Y];
  assign stack_ptr = gpr[R_SP];

endmodule : ldst_exec

// *** design/ldst_pkg.sv ***
// Shared types and constants for the load, store and transfer executor.
package ldst_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register file order: accumulator, X, Y, stack pointer.
  localparam logic [3:0][7:0] RST_GPR   = {8'hff, 8'h00, 8'h00, 8'h00};
  localparam logic            RST_FLAG  = 1'h0;
  localparam logic [2:0]      CNT_FIRST = 3'h1;
  localparam logic [2:0]      CNT_RST   = 3'h0;
  localparam logic [1:0]      BYTES_RST = 2'h0;
  localparam logic [7:0]      BYTE_ONE  = 8'h01;
  localparam logic [6:0]      PAGE_PAD  = 7'h00;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_PLO  = 6'h04,
    S_PHI  = 6'h08,
    S_RD   = 6'h10,
    S_WAIT = 6'h20
  } ldst_state_t;

  typedef enum logic [2:0] {
    K_NONE, K_LOAD, K_STORE, K_STIMM, K_COPY, K_SWAPR, K_SWAPM
  } ldst_kind_t;

  typedef enum logic [3:0] {
    M_NONE, M_IMM, M_DP, M_DPX, M_DPY, M_ABS, M_ABSY, M_IDXIND, M_INDIDX, M_XIND
  } ldst_mode_t;

  typedef enum logic [1:0] {R_A, R_X, R_Y, R_SP} ldst_reg_t;

  typedef struct packed {
    ldst_kind_t  kind;
    ldst_mode_t  mode;
    ldst_reg_t   src;
    ldst_reg_t   dst;
    logic [1:0]  nbytes;
    logic [2:0]  ncyc;
    logic        nz;
    logic        incx;
    logic        legal;
  } ldst_entry_t;

endpackage : ldst_pkg

// *** design/ldst_decode.sv ***
// Opcode table of the load, store, transfer and exchange group.
`timescale 1ns/100ps
module ldst_decode
  import ldst_pkg::*;
(
  // Opcode in.
  input  wire logic [7:0]  opcode,
  // Decoded entry out.
  output ldst_pkg::ldst_entry_t entry
);

  function automatic ldst_entry_t mk(ldst_kind_t k, ldst_mode_t m, ldst_reg_t s,
                                     ldst_reg_t d, logic [1:0] b, logic [2:0] c,
                                     logic nz, logic inc);
    ldst_entry_t e;
    e = '{k, m, s, d, b, c, nz, inc, 1'h1};
    return e;
  endfunction : mk

  function automatic ldst_entry_t lookup(logic [7:0] op);
    ldst_entry_t e;
    e = '{K_NONE, M_NONE, R_A, R_A, 2'h0, 3'h2, 1'h0, 1'h0, 1'h0};
    case (op)
      8'hc4: e = mk(K_LOAD, M_IMM, R_A, R_A, 2'h2, 3'h2, 1'h1, 1'h0);
      8'hc5: e = mk(K_LOAD, M_DP, R_A, R_A, 2'h2, 3'h3, 1'h1, 1'h0);
      8'hc6: e = mk(K_LOAD, M_DPX, R_A, R_A, 2'h2, 3'h4, 1'h1, 1'h0);
      8'hc7: e = mk(K_LOAD, M_ABS, R_A, R_A, 2'h3, 3'h4, 1'h1, 1'h0);
      8'hd5: e = mk(K_LOAD, M_ABSY, R_A, R_A, 2'h3, 3'h5, 1'h1, 1'h0);
      8'hd6: e = mk(K_LOAD, M_IDXIND, R_A, R_A, 2'h2, 3'h6, 1'h1, 1'h0);
      8'hd7: e = mk(K_LOAD, M_INDIDX, R_A, R_A, 2'h2, 3'h6, 1'h1, 1'h0);
      8'hd4: e = mk(K_LOAD, M_XIND, R_A, R_A, 2'h1, 3'h3, 1'h1, 1'h0);
      8'hdb: e = mk(K_LOAD, M_XIND, R_A, R_A, 2'h1, 3'h4, 1'h1, 1'h1);
      8'he4: e = mk(K_STIMM, M_DP, R_A, R_A, 2'h3, 3'h5, 1'h0, 1'h0);
      8'h1e: e = mk(K_LOAD, M_IMM, R_X, R_X, 2'h2, 3'h2, 1'h1, 1'h0);
      8'hcc: e = mk(K_LOAD, M_DP, R_X, R_X, 2'h2, 3'h3, 1'h1, 1'h0);
      8'hcd: e = mk(K_LOAD, M_DPY, R_X, R_X, 2'h2, 3'h4, 1'h1, 1'h0);
      8'hdc: e = mk(K_LOAD, M_ABS, R_X, R_X, 2'h3, 3'h4, 1'h1, 1'h0);
      8'h3e: e = mk(K_LOAD, M_IMM, R_Y, R_Y, 2'h2, 3'h2, 1'h1, 1'h0);
      8'hc9: e = mk(K_LOAD, M_DP, R_Y, R_Y, 2'h2, 3'h3, 1'h1, 1'h0);
      8'hd9: e = mk(K_LOAD, M_DPX, R_Y, R_Y, 2'h2, 3'h4, 1'h1, 1'h0);
      8'hd8: e = mk(K_LOAD, M_ABS, R_Y, R_Y, 2'h3, 3'h4, 1'h1, 1'h0);
      8'he5: e = mk(K_STORE, M_DP, R_A, R_A, 2'h2, 3'h4, 1'h0, 1'h0);
      8'he6: e = mk(K_STORE, M_DPX, R_A, R_A, 2'h2, 3'h5, 1'h0, 1'h0);
      8'he7: e = mk(K_STORE, M_ABS, R_A, R_A, 2'h3, 3'h5, 1'h0, 1'h0);
      8'hf5: e = mk(K_STORE, M_ABSY, R_A, R_A, 2'h3, 3'h6, 1'h0, 1'h0);
      8'hf6: e = mk(K_STORE, M_IDXIND, R_A, R_A, 2'h2, 3'h7, 1'h0, 1'h0);
      8'hf7: e = mk(K_STORE, M_INDIDX, R_A, R_A, 2'h2, 3'h7, 1'h0, 1'h0);
      8'hf4: e = mk(K_STORE, M_XIND, R_A, R_A, 2'h1, 3'h4, 1'h0, 1'h0);
      8'hfb: e = mk(K_STORE, M_XIND, R_A, R_A, 2'h1, 3'h4, 1'h0, 1'h1);
      8'hec: e = mk(K_STORE, M_DP, R_X, R_X, 2'h2, 3'h4, 1'h0, 1'h0);
      8'hed: e = mk(K_STORE, M_DPY, R_X, R_X, 2'h2, 3'h5, 1'h0, 1'h0);
      8'hfc: e = mk(K_STORE, M_ABS, R_X, R_X, 2'h3, 3'h5, 1'h0, 1'h0);
      8'he9: e = mk(K_STORE, M_DP, R_Y, R_Y, 2'h2, 3'h4, 1'h0, 1'h0);
      8'hf9: e = mk(K_STORE, M_DPX, R_Y, R_Y, 2'h2, 3'h5, 1'h0, 1'h0);
      8'hf8: e = mk(K_STORE, M_ABS, R_Y, R_Y, 2'h3, 3'h5, 1'h0, 1'h0);
      8'he8: e = mk(K_COPY, M_NONE, R_A, R_X, 2'h1, 3'h2, 1'h1, 1'h0);
      8'h9f: e = mk(K_COPY, M_NONE, R_A, R_Y, 2'h1, 3'h2, 1'h1, 1'h0);
      8'hae: e = mk(K_COPY, M_NONE, R_SP, R_X, 2'h1, 3'h2, 1'h1, 1'h0);
      8'hc8: e = mk(K_COPY, M_NONE, R_X, R_A, 2'h1, 3'h2, 1'h1, 1'h0);
      8'h8e: e = mk(K_COPY, M_NONE, R_X, R_SP, 2'h1, 3'h2, 1'h1, 1'h0);
      8'hbf: e = mk(K_COPY, M_NONE, R_Y, R_A, 2'h1, 3'h2, 1'h1, 1'h0);
      8'hee: e = mk(K_SWAPR, M_NONE, R_X, R_A, 2'h1, 3'h4, 1'h0, 1'h0);
      8'hde: e = mk(K_SWAPR, M_NONE, R_Y, R_A, 2'h1, 3'h4, 1'h0, 1'h0);
      8'hfe: e = mk(K_SWAPR, M_NONE, R_X, R_Y, 2'h1, 3'h4, 1'h0, 1'h0);
      8'hbc: e = mk(K_SWAPM, M_DP, R_A, R_A, 2'h2, 3'h5, 1'h1, 1'h0);
      8'had: e = mk(K_SWAPM, M_DPX, R_A, R_A, 2'h2, 3'h6, 1'h1, 1'h0);
      8'hbb: e = mk(K_SWAPM, M_XIND, R_A, R_A, 2'h1, 3'h5, 1'h1, 1'h0);
      default: e.legal = 1'h0;
    endcase
    return e;
  endfunction : lookup

  assign entry = lookup(opcode);

endmodule : ldst_decode

// *** test/ldst_exec_monitor.sv ***
// Concurrent checks on the ports of the load, store and transfer executor.
`timescale 1ns/100ps
module ldst_exec_monitor
  import ldst_pkg::*;
(
  // Clock and reset.
  input wire logic                        mclk,
  input wire logic                        rstn,
  // Instruction port.
  input wire logic                        start,
  input wire logic [7:0]                  opcode,
  input wire logic [7:0]                  operand1,
  input wire logic [7:0]                  operand2,
  input wire logic                        page_sel,
  input wire logic                        busy,
  input wire logic                        done,
  input wire logic                        illegal,
  input wire logic [1:0]                  byte_count,
  // Memory and registers.
  input wire logic [ldst_pkg::ADDR_W-1:0] mem_addr,
  input wire logic                        mem_rd,
  input wire logic                        mem_wr,
  input wire logic [ldst_pkg::DATA_W-1:0] mem_wdata,
  input wire logic [ldst_pkg::DATA_W-1:0] mem_rdata,
  input wire logic [7:0]                  acc,
  input wire logic [7:0]                  idx_x,
  input wire logic [7:0]                  idx_y,
  input wire logic [7:0]                  stack_ptr,
  input wire logic                        flag_n,
  input wire logic                        flag_z
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence take(logic [7:0] op);
    start && !busy && opcode == op;
  endsequence

  // The pointer index is sampled before the increment lands.
  sequence at_x;
    mem_addr[7:0] == idx_x;
  endsequence

  AST_ILL_PULSE: assert property (illegal |-> done && byte_count == 2'h0)
    else $error("illegal pulse without done or with a length");
  AST_TAX: assert property (take(8'he8) |-> ##2 done && idx_x == $past(acc, 2)
    && flag_n == idx_x[7] && flag_z == (idx_x == 8'h00))
    else $error("copy of acc to x wrong");
  AST_IMM_WR: assert property (take(8'he4) |-> ##2 mem_wr && mem_wdata == $past(operand2, 2)
    && mem_addr == {7'h00, $past(page_sel, 2), $past(operand1, 2)})
    else $error("immediate write wrong");
  AST_IMM_DONE: assert property (take(8'he4) |-> ##1 !done [*4] ##1 done
    && flag_n == $past(flag_n, 5) && flag_z == $past(flag_z, 5))
    else $error("immediate write timing or flags wrong");
  AST_LD_INC: assert property (take(8'hdb) |-> ##2 (mem_rd and at_x) ##2 done
    && idx_x == $past(idx_x, 4) + 8'h01 && acc == $past(mem_rdata, 2) && flag_n == acc[7])
    else $error("load with increment wrong");
  AST_ST_INC: assert property (take(8'hfb) |-> ##2 (mem_wr and at_x) ##2 done
    && mem_wdata == acc && idx_x == $past(idx_x, 4) + 8'h01)
    else $error("store with increment wrong");
  AST_XY_SWAP: assert property (take(8'hfe) |-> ##4 done && idx_x == $past(idx_y, 4)
    && idx_y == $past(idx_x, 4) && flag_n == $past(flag_n, 4) && flag_z == $past(flag_z, 4))
    else $error("swap of x and y wrong");
  AST_MEM_SWAP: assert property (take(8'hbc) |-> ##2 mem_rd ##1 mem_wr && mem_wdata == acc
    ##2 done && acc == $past(mem_rdata, 3) && flag_z == (acc == 8'h00))
    else $error("swap with memory wrong");
  AST_STORE_A: assert property (take(8'he5) |-> ##2 mem_wr && mem_wdata == acc
    && mem_addr == {7'h00, $past(page_sel, 2), $past(operand1, 2)} ##1 !done ##1 done
    && flag_n == $past(flag_n, 4))
    else $error("accumulator store wrong");
  AST_COPY_SP: assert property (take(8'h8e) |-> ##2 done && stack_ptr == idx_x
    && flag_z == (idx_x == 8'h00))
    else $error("copy of x to stack pointer wrong");
endmodule : ldst_exec_monitor

bind ldst_exec ldst_exec_monitor i_mon (.mclk(mclk), .rstn(rstn), .start(start),
  .opcode(opcode), .operand1(operand1), .operand2(operand2), .page_sel(page_sel),
  .busy(busy), .done(done), .illegal(illegal), .byte_count(byte_count),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .acc(acc), .idx_x(idx_x), .idx_y(idx_y),
  .stack_ptr(stack_ptr), .flag_n(flag_n), .flag_z(flag_z));

// *** test/ldst_mem_model.sv ***
// Data memory behind the executor: read settles in the cycle, write on the edge.
`timescale 1ns/100ps
module ldst_mem_model
(
  // Clock.
  input wire logic        mclk,
  // Access from the executor.
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  output logic [7:0]      mem_rdata
);
  logic [7:0] store [0:65535];
  logic [7:0] last;
  // Outside a read the bus shows the inverse of the last byte, so a stale value never passes.
  assign mem_rdata = mem_rd ? store[mem_addr] : ~last;
  initial
  begin
    last = 8'h00;
    for (int i = 0; i < 65536; i++)
      store[i] = i[7:0] ^ 8'h5a;
  end
  always @(posedge mclk)
  begin
    if (mem_rd)
      last <= store[mem_addr];
    if (mem_wr)
      store[mem_addr] <= mem_wdata;
  end
endmodule : ldst_mem_model

// *** test/tb_cpu_load_store_transfer_decode.sv ***
// Self-checking bench of the load, store and transfer executor.
`timescale 1ns/100ps
`define LDST_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_cpu_load_store_transfer_decode;
  import ldst_pkg::*;
  logic mclk, rstn, start, page_sel, busy, done, illegal, mem_rd, mem_wr, flag_n, flag_z;
  logic [7:0] opcode, operand1, operand2, mem_wdata, mem_rdata, acc, idx_x, idx_y, stack_ptr;
  logic [1:0] byte_count;
  logic [15:0] mem_addr, last_wa;
  logic [7:0] last_wd, n;
  int miscompares, samples_checked;
  // Each row: opcode, then length in bytes and cycle count; the last row is not in the group.
  localparam logic [15:0] ROWS [45] = '{16'hc422, 16'hc523, 16'hc624, 16'hc734, 16'hd535,
    16'hd626, 16'hd726, 16'hd413, 16'hdb14, 16'he435, 16'h1e22, 16'hcc23, 16'hcd24, 16'hdc34,
    16'h3e22, 16'hc923, 16'hd924, 16'hd834, 16'he524, 16'he625, 16'he735, 16'hf536, 16'hf627,
    16'hf727, 16'hf414, 16'hfb14, 16'hec24, 16'hed25, 16'hfc35, 16'he924, 16'hf925, 16'hf835,
    16'he812, 16'h9f12, 16'hae12, 16'hc812, 16'h8e12, 16'hbf12, 16'hee14, 16'hde14, 16'hbc25,
    16'had26, 16'hbb15, 16'hfe14, 16'h0001};

  ldst_exec i_dut (.mclk(mclk), .rstn(rstn), .start(start), .opcode(opcode),
    .operand1(operand1), .operand2(operand2), .page_sel(page_sel), .busy(busy), .done(done),
    .illegal(illegal), .byte_count(byte_count), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc(acc), .idx_x(idx_x),
    .idx_y(idx_y), .stack_ptr(stack_ptr), .flag_n(flag_n), .flag_z(flag_z));
  ldst_mem_model i_mem (.mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (mem_wr === 1'b1)
    begin
      last_wa <= mem_addr;
      last_wd <= mem_wdata;
    end
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Hands over one instruction and counts cycles until done, cycle 1 being the take.
  task automatic issue(input logic [7:0] op, input logic [7:0] o1, input logic ps);
    @(posedge mclk);
    start <= 1'b1;
    opcode <= op;
    operand1 <= o1;
    operand2 <= o1 ^ 8'h41;
    page_sel <= ps;
    @(posedge mclk);
    start <= 1'b0;
    n = 8'h01;
    #1;
    while (done !== 1'b1 && n < 8'h14)
    begin
      @(posedge mclk);
      #1;
      n = n + 8'h01;
    end
    if (n == 8'h14)
    begin
      miscompares++;
      $display("[FAIL] done never came for %h", op);
      conclude();
    end
  endtask : issue

  initial
  begin
    rstn = 1'b0;
    start = 1'b0;
    opcode = 8'h00;
    operand1 = 8'h00;
    operand2 = 8'h00;
    page_sel = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    `LDST_CHK("reset sp", 8'hff, stack_ptr)
    `LDST_CHK("reset regs", 28'h0000000, {acc, idx_x, idx_y, flag_n, flag_z, busy, done})
    foreach (ROWS[i])
    begin
      issue(ROWS[i][15:8], 8'h40, 1'b0);
      `LDST_CHK("cycles", ROWS[i][3:0], n[3:0])
      `LDST_CHK("bytes", ROWS[i][5:4], byte_count)
    end
    // Operand2 is operand1 xor 41, so 33 makes the immediate 72 at page 1 address 0133.
    issue(8'he4, 8'h33, 1'b1);
    `LDST_CHK("imm addr", 16'h0133, last_wa)
    `LDST_CHK("imm data", 8'h72, last_wd)
    issue(8'hc5, 8'h33, 1'b1);
    `LDST_CHK("load dp", 10'h1c8, {acc, flag_n, flag_z})
    issue(8'he4, 8'h41, 1'b1);
    issue(8'hcc, 8'h41, 1'b1);
    `LDST_CHK("load x zero", 10'h001, {idx_x, flag_n, flag_z})
    issue(8'h3e, 8'h05, 1'b0);
    issue(8'hc4, 8'h80, 1'b0);
    issue(8'he8, 8'h00, 1'b0);
    `LDST_CHK("copy a to x", 10'h202, {idx_x, flag_n, flag_z})
    issue(8'hfe, 8'h00, 1'b0);
    `LDST_CHK("swap x y", 18'h01602, {idx_x, idx_y, flag_n, flag_z})
    issue(8'h1e, 8'h33, 1'b0);
    issue(8'hdb, 8'h00, 1'b1);
    `LDST_CHK("load inc", 16'h7234, {acc, idx_x})
    issue(8'hfb, 8'h00, 1'b1);
    `LDST_CHK("store inc", 32'h01347235, {last_wa, last_wd, idx_x})
    issue(8'h8e, 8'h00, 1'b0);
    `LDST_CHK("copy x to sp", 10'h0d4, {stack_ptr, flag_n, flag_z})
    issue(8'hc4, 8'h00, 1'b0);
    issue(8'hbc, 8'h34, 1'b1);
    `LDST_CHK("swap mem", 10'h1c8, {acc, flag_n, flag_z})
    `LDST_CHK("swap mem wr", 8'h00, last_wd)
    issue(8'h00, 8'h00, 1'b0);
    `LDST_CHK("illegal pulse", 3'b110, {illegal, done, busy})
    `LDST_CHK("illegal keeps", 12'h720, {acc, byte_count, flag_n, flag_z})
    @(posedge mclk);
    rstn <= 1'b0;
    #1;
    `LDST_CHK("second reset", 16'hff00, {stack_ptr, acc})
    @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    `LDST_CHK("after release", 10'h0ff, {busy, done, stack_ptr})
    issue(8'h9f, 8'h00, 1'b0);
    `LDST_CHK("copy a to y", 10'h001, {idx_y, flag_n, flag_z})
    conclude();
  end
endmodule : tb_cpu_load_store_transfer_decode
